// File: verilog/sad_pkg.sv
// shared constants and types of the system address decoder
package sad_pkg;
	localparam int NMST = 2;
	localparam int NSLV = 30;
	localparam int MEM_SLOTS = 3;
	localparam int APB_FIRST = 3;
	localparam int APB_LAST = 21;
	localparam int SRAM_WORDS = 1024;
	localparam int SRAM_AW = 10;

	localparam logic [2:0] REG_CODE = 3'h0;
	localparam logic [2:0] REG_SRAM = 3'h1;
	localparam logic [2:0] REG_PERI = 3'h2;
	localparam logic [31:0] ALIAS_LAST = 32'h0001_FFFF;
	localparam logic [31:0] FLASH_BASE = 32'h0800_0000;
	localparam logic [31:0] SYSMEM_BASE = 32'h1FFF_F400;
	localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
	localparam logic [31:0] SRAM_LAST = 32'h2000_0FFF;
	localparam logic [31:0] FLASH_SPAN = 32'h0000_7FFF;
	localparam logic [31:0] OPT_SPAN = 32'h0000_000F;
	localparam logic [31:0] KB_SPAN = 32'h0000_03FF;

	// slot bases: flash, system memory, option bytes, apb1, apb2, ahb, gpio
	localparam logic [31:0] SLV_BASE [NSLV] = '{
		32'h0800_0000, 32'h1FFF_F400, 32'h1FFF_F800,
		32'h4000_0000, 32'h4000_0400, 32'h4000_2C00, 32'h4000_3000,
		32'h4000_3800, 32'h4000_4400, 32'h4000_5400, 32'h4000_7000,
		32'h4001_0000, 32'h4001_0400, 32'h4001_2400, 32'h4001_2C00,
		32'h4001_3000, 32'h4001_3400, 32'h4001_3800, 32'h4001_3C00,
		32'h4001_4000, 32'h4001_4400, 32'h4001_4800,
		32'h4002_0000, 32'h4002_1000, 32'h4002_2000, 32'h4003_0000,
		32'h4800_0000, 32'h4800_0400, 32'h4800_0800, 32'h4800_0C00};
	localparam logic [NSLV-1:0] MEM_CLK_ON = 30'h0000_0007;

	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [2:0] BOOT_LATCH_CNT = 3'h3;
	localparam logic [2:0] BOOT_CNT_ONE = 3'h1;

	typedef enum logic [2:0] {
		BOOT_FLASH = 3'b001,
		BOOT_SYSMEM = 3'b010,
		BOOT_SRAM = 3'b100
	} sad_boot_t;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_SLAVE = 3'b010,
		PH_DONE = 3'b100
	} sad_phase_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} sad_req_t;

	typedef struct packed {
		logic        ready;
		logic        err;
		logic [31:0] rdata;
	} sad_ans_t;

	typedef struct packed {
		logic            valid;
		logic [NSLV-1:0] sel;
		logic            write;
		logic [1:0]      size;
		logic [31:0]     addr;
		logic [31:0]     wdata;
	} sad_slv_t;

	typedef struct packed {
		sad_phase_t           phase;
		logic                 owner;
		logic                 last;
		sad_ans_t [NMST-1:0]  ans;
		sad_slv_t             slv;
		logic [NSLV-1:0]      clk_en;
		logic [2:0]           boot_cnt;
		logic                 boot_done;
		sad_boot_t            boot_mode;
	} sad_state_t;
endpackage

// File: verilog/sad_crossbar.sv
// master crossbar with address decoder, boot alias and on-chip sram
`timescale 1ns/10ps
module sad_crossbar
	import sad_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	// masters: 0 cpu system bus, 1 dma
	input  wire sad_req_t [NMST-1:0]   m_req,
	output sad_ans_t [NMST-1:0]        m_ans,
	// shared slave path
	output sad_slv_t                   s_req,
	input  wire logic [31:0]           s_rdata,
	input  wire logic                  s_ready,
	input  wire logic                  s_err,
	// boot straps and wakeup
	input  wire logic                  boot_select_pin,
	input  wire logic                  boot_option_bit,
	input  wire logic                  standby_wake,
	// peripheral clock gating
	input  wire logic [NSLV-1:0]       clk_en_req,
	output logic [NSLV-1:0]            clk_en,
	// boot status
	output sad_boot_t                  boot_mode,
	output logic                       boot_done
);

	sad_state_t      st_reg;
	sad_state_t      st_next;
	logic [31:0]     sram_mem [SRAM_WORDS];
	logic            pick;
	sad_req_t        req;
	logic [31:0]     taddr;
	logic [31:0]     alias_span;
	logic [NSLV-1:0] hit;
	logic            is_sram;
	logic            is_apb;
	logic            reserved;
	logic            take;
	logic            sram_we;
	logic [3:0]      be;
	logic [31:0]     rep_wdata;
	logic [SRAM_AW-1:0] sidx;

	// round robin pick, other master wins on a tie
	always_comb
	begin
		if (m_req[0].valid && m_req[1].valid)
			pick = ~st_reg.last;
		else
			pick = m_req[1].valid;
	end

	assign req = m_req[pick];
	assign take = (st_reg.phase == PH_IDLE) && st_reg.boot_done && req.valid;

	// boot alias translation
	always_comb
	begin
		taddr = req.addr;
		alias_span = FLASH_SPAN;
		if (req.addr <= ALIAS_LAST)
		begin
			case (st_reg.boot_mode)
				BOOT_SYSMEM:
				begin
					taddr = SYSMEM_BASE + {15'h0, req.addr[16:0]};
					alias_span = KB_SPAN;
				end
				BOOT_SRAM:
				begin
					taddr = SRAM_BASE + {15'h0, req.addr[16:0]};
					alias_span = SRAM_LAST - SRAM_BASE;
				end
				default:
				begin
					taddr = FLASH_BASE + {15'h0, req.addr[16:0]};
					alias_span = FLASH_SPAN;
				end
			endcase
			// past the target size: all ones lands in a reserved region
			if ({15'h0, req.addr[16:0]} > alias_span)
				taddr = '1;
		end
	end

	// slot compare, one per slave
	genvar gi;
	generate
		for (gi = 0; gi < NSLV; gi++)
		begin : g_dec
			localparam logic [31:0] SPAN = (gi == 0) ? FLASH_SPAN :
				(gi == 2) ? OPT_SPAN : KB_SPAN;
			assign hit[gi] = (taddr[31:29] <= REG_PERI) &&
				(taddr >= SLV_BASE[gi]) &&
				(taddr <= SLV_BASE[gi] + SPAN);
		end
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			localparam logic [1:0] LN = 2'(gi);
			assign be[gi] = (req.size == SZ_WORD) ||
				(req.size == SZ_HALF && taddr[1] == LN[1]) ||
				(req.size == SZ_BYTE && taddr[1:0] == LN);
		end
	endgenerate

	assign is_sram = (taddr[31:29] == REG_SRAM) && (taddr >= SRAM_BASE) &&
		(taddr <= SRAM_LAST);
	assign is_apb = |hit[APB_LAST:APB_FIRST];
	assign reserved = !is_sram && (hit == '0);
	assign sram_we = take && is_sram && req.write;
	assign sidx = taddr[SRAM_AW+1:2];

	// narrow data copied to every lane for the apb bridges
	always_comb
	begin
		case (req.size)
			SZ_BYTE: rep_wdata = {4{req.wdata[8*taddr[1:0] +: 8]}};
			SZ_HALF: rep_wdata = {2{req.wdata[16*taddr[1] +: 16]}};
			default: rep_wdata = req.wdata;
		endcase
	end

	// sram storage, written by lane
	always_ff @(posedge clk)
	begin
		for (int k = 0; k < 4; k++)
		begin
			if (sram_we && be[k])
				sram_mem[sidx][8*k +: 8] <= req.wdata[8*k +: 8];
		end
	end

	always_comb
	begin
		st_next = st_reg;
		for (int m = 0; m < NMST; m++)
		begin
			st_next.ans[m].ready = 1'b0;
			st_next.ans[m].err = 1'b0;
		end
		st_next.clk_en = clk_en_req | MEM_CLK_ON;
		// boot sampling
		if (standby_wake)
		begin
			st_next.boot_cnt = '0;
			st_next.boot_done = 1'b0;
		end
		else if (!st_reg.boot_done)
		begin
			st_next.boot_cnt = st_reg.boot_cnt + BOOT_CNT_ONE;
			if (st_reg.boot_cnt == BOOT_LATCH_CNT)
			begin
				st_next.boot_done = 1'b1;
				if (!boot_select_pin)
					st_next.boot_mode = BOOT_FLASH;
				else if (boot_option_bit)
					st_next.boot_mode = BOOT_SRAM;
				else
					st_next.boot_mode = BOOT_SYSMEM;
			end
		end
		case (st_reg.phase)
			PH_IDLE:
			begin
				if (take)
				begin
					st_next.owner = pick;
					st_next.last = pick;
					st_next.phase = PH_DONE;
					if (reserved)
					begin
						st_next.ans[pick].ready = 1'b1;
						st_next.ans[pick].err = 1'b1;
						st_next.ans[pick].rdata = '0;
					end
					else if (is_sram)
					begin
						st_next.ans[pick].ready = 1'b1;
						st_next.ans[pick].rdata = sram_mem[sidx];
					end
					else
					begin
						st_next.slv.valid = 1'b1;
						st_next.slv.sel = hit;
						st_next.slv.write = req.write;
						st_next.slv.size = req.size;
						st_next.slv.addr = taddr;
						st_next.slv.wdata = is_apb ? rep_wdata : req.wdata;
						st_next.phase = PH_SLAVE;
					end
				end
			end
			PH_SLAVE:
			begin
				if (s_ready)
				begin
					st_next.slv.valid = 1'b0;
					st_next.slv.sel = '0;
					st_next.ans[st_reg.owner].ready = 1'b1;
					st_next.ans[st_reg.owner].err = s_err;
					st_next.ans[st_reg.owner].rdata = s_rdata;
					st_next.phase = PH_DONE;
				end
			end
			PH_DONE:
				st_next.phase = PH_IDLE;
			default:
				st_next.phase = PH_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg <= '0;
			st_reg.phase <= PH_IDLE;
			st_reg.clk_en <= MEM_CLK_ON;
			st_reg.boot_mode <= BOOT_FLASH;
		end
		else
			st_reg <= st_next;
	end

	assign m_ans = st_reg.ans;
	assign s_req = st_reg.slv;
	assign clk_en = st_reg.clk_en;
	assign boot_mode = st_reg.boot_mode;
	assign boot_done = st_reg.boot_done;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	AST_ONE_OWNER: assert property (
		!(m_ans[0].ready && m_ans[1].ready))
		else $error("both masters answered at once");
	AST_RESERVED_ZERO: assert property (
		take && reserved |=> m_ans[$past(pick)].err &&
			m_ans[$past(pick)].rdata == '0 && !s_req.valid)
		else $error("reserved access not refused");
	AST_SEL_ONEHOT: assert property (
		$onehot0(s_req.sel) && (s_req.valid == (s_req.sel != '0)))
		else $error("slave select not one-hot");
	AST_APB_REPLICATE: assert property (
		s_req.valid && |s_req.sel[APB_LAST:APB_FIRST] &&
		s_req.size == SZ_BYTE |->
			s_req.wdata == {4{s_req.wdata[7:0]}})
		else $error("narrow apb data not replicated");
	AST_BOOT_WAIT: assert property (
		$rose(rst_b) |-> !boot_done [*4] ##1 $rose(boot_done))
		else $error("boot not latched on fourth edge");
	AST_BOOT_ENC: assert property (
		$rose(boot_done) |-> boot_mode == (!$past(boot_select_pin) ?
			BOOT_FLASH : $past(boot_option_bit) ? BOOT_SRAM : BOOT_SYSMEM))
		else $error("boot mode encoding wrong");
	AST_MEM_CLOCKS: assert property (
		clk_en[MEM_SLOTS-1:0] == MEM_CLK_ON[MEM_SLOTS-1:0] &&
		(clk_en[NSLV-1:MEM_SLOTS] == $past(clk_en_req[NSLV-1:MEM_SLOTS])))
		else $error("peripheral clock gating wrong");
	AST_SLAVE_HOLD: assert property (
		s_req.valid && !s_ready |=> s_req.valid && $stable(s_req.addr) &&
			!m_ans[0].ready && !m_ans[1].ready)
		else $error("grant dropped before slave ready");
	AST_SRAM_NOWAIT: assert property (
		take && is_sram |=> m_ans[$past(pick)].ready ##1
			st_reg.phase == PH_IDLE)
		else $error("sram access waited");
	AST_ALIAS_FLASH: assert property (
		take && boot_mode == BOOT_FLASH && req.addr <= ALIAS_LAST &&
		req.addr[16:15] == 2'h0 |=> s_req.sel[0])
		else $error("flash alias not decoded");
	AST_ALIAS_SYSMEM: assert property (
		take && boot_mode == BOOT_SYSMEM && req.addr <= ALIAS_LAST |=>
			m_ans[$past(pick)].err || (s_req.valid &&
			s_req.addr >= SYSMEM_BASE && s_req.addr <= SYSMEM_BASE + KB_SPAN))
		else $error("system memory alias not decoded");
	AST_ALIAS_SRAM: assert property (
		take && boot_mode == BOOT_SRAM && req.addr <= ALIAS_LAST |=>
			!s_req.valid && m_ans[$past(pick)].ready)
		else $error("sram alias left the sram");
	AST_NO_EARLY_TAKE: assert property (
		!boot_done && !s_req.valid |=>
			!s_req.valid && !m_ans[0].ready && !m_ans[1].ready)
		else $error("request taken before boot latch");
	AST_WAKE_RESAMPLE: assert property (
		standby_wake |=> !boot_done [*4] ##1 boot_done)
		else $error("boot not resampled after wake");
	AST_BOOT_STABLE: assert property (
		boot_done |=> $stable(boot_mode))
		else $error("boot mode changed after latch");
	AST_APB_HALF: assert property (
		s_req.valid && |s_req.sel[APB_LAST:APB_FIRST] &&
		s_req.size == SZ_HALF |->
			s_req.wdata == {2{s_req.wdata[15:0]}})
		else $error("apb halfword data not replicated");
	AST_SLAVE_RANGE: assert property (
		s_req.valid |-> s_req.addr[31:29] <= REG_PERI &&
			!(s_req.addr >= SRAM_BASE && s_req.addr <= SRAM_LAST))
		else $error("slave path used outside decoded regions");
	AST_ANSWER_GAP: assert property (
		m_ans[0].ready || m_ans[1].ready |=>
			!m_ans[0].ready && !m_ans[1].ready)
		else $error("answers not separated by an idle cycle");
	AST_SLAVE_DONE: assert property (
		s_req.valid && s_ready |=> !s_req.valid &&
			(m_ans[0].ready || m_ans[1].ready))
		else $error("slave answer not returned to the owner");
	AST_SRAM_LOCAL: assert property (
		take && is_sram |=> !s_req.valid && !m_ans[$past(pick)].err)
		else $error("sram access left the sram");

	COV_SRAM: cover property (take && is_sram && req.write);
	COV_RESERVED: cover property (take && reserved);
	COV_APB: cover property (take && is_apb ##[1:20] s_ready);
	COV_CONTEND: cover property (m_req[0].valid && m_req[1].valid && take);
	COV_WAKE: cover property (standby_wake ##5 boot_done);

endmodule // sad_crossbar

// File: verification/sad_slave_model.sv
// far-side slave model answering the shared slave path
`timescale 1ns/10ps
module sad_slave_model
	import sad_pkg::*;
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_b,
	// slave path
	input  wire sad_slv_t      s_req,
	input  wire logic [1:0]    wait_cyc,
	output logic [31:0]        s_rdata,
	output logic               s_ready,
	output logic               s_err,
	// last access answered, read or write
	output logic [31:0]        last_wdata,
	output logic [NSLV-1:0]    last_sel
);
	logic [1:0] cnt;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			cnt <= 2'h0;
			s_ready <= 1'b0;
			s_err <= 1'b0;
			s_rdata <= 32'h0;
			last_wdata <= 32'h0;
			last_sel <= '0;
		end
		else if (s_req.valid && !s_ready && cnt == wait_cyc)
		begin
			s_ready <= 1'b1;
			// longest wait answers with an error
			s_err <= (wait_cyc == 2'h3);
			s_rdata <= s_req.addr ^ 32'hA5A5_5A5A;
			last_wdata <= s_req.wdata;
			last_sel <= s_req.sel;
		end
		else
		begin
			// data invalid outside answers
			s_ready <= 1'b0;
			s_err <= 1'b0;
			s_rdata <= ~s_rdata;
			cnt <= s_req.valid ? cnt + 2'h1 : 2'h0;
		end
endmodule // sad_slave_model

// File: verification/system_address_decoder_tb.sv
// self-checking bench of the system address decoder
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module system_address_decoder_tb;
	import sad_pkg::*;
	logic                clk = 1'b0;
	logic                rst_b = 1'b0;
	sad_req_t [NMST-1:0] m_req = '0;
	sad_ans_t [NMST-1:0] m_ans;
	sad_slv_t            s_req;
	logic [31:0]         s_rdata, lw, a, w;
	logic                s_ready, s_err, bd;
	logic                bp = 1'b1, bo = 1'b1, wake = 1'b0;
	logic [NSLV-1:0]     cer = '0, ce, ls, pl;
	sad_boot_t           bm;
	logic [1:0]          wc = 2'h0;
	logic [33:0]         eq [NMST][$];
	logic [33:0]         ex;
	int                  err_total = 0, n_tests = 0, k, lat;
	localparam logic [31:0] K = 32'hA5A5_5A5A;
	localparam logic [31:0] RSV [9] = '{32'h0002_0000, 32'h0000_1000,
		32'h0800_8000, 32'h1FFF_F810, 32'h2000_1000, 32'h4000_0800,
		32'h4001_4C00, 32'h4800_1000, 32'hE000_0000};
	always #10 clk = ~clk;
	sad_crossbar u_sad_crossbar (.clk(clk), .rst_b(rst_b), .m_req(m_req),
		.m_ans(m_ans), .s_req(s_req), .s_rdata(s_rdata),
		.s_ready(s_ready), .s_err(s_err), .boot_select_pin(bp),
		.boot_option_bit(bo), .standby_wake(wake), .clk_en_req(cer),
		.clk_en(ce), .boot_mode(bm), .boot_done(bd));
	sad_slave_model u_sad_slave_model (.clk(clk), .rst_b(rst_b),
		.s_req(s_req), .wait_cyc(wc), .s_rdata(s_rdata),
		.s_ready(s_ready), .s_err(s_err), .last_wdata(lw),
		.last_sel(ls));
	function automatic logic [33:0] rd(input logic [31:0] x);
		return {2'b10, x};
	endfunction
	task automatic xfer(input int i, input logic wr, input logic [1:0] sz,
		input logic [31:0] ad, input logic [31:0] d, input logic [33:0] e);
		int n;
		begin
			n = 0;
			eq[i].push_back(e);
			m_req[i] <= {1'b1, wr, sz, ad, d};
			@(negedge clk);
			while (m_ans[i].ready !== 1'b1 && n < 60)
			begin
				n++;
				@(negedge clk);
			end
			lat = n;
			m_req[i].valid <= 1'b0;
			if (n >= 60)
				err_total++;
			@(negedge clk);
		end
	endtask
	task automatic boot(input logic p, input logic o, input sad_boot_t m,
		input logic [31:0] base, input int slot);
		begin
			bp <= p;
			bo <= o;
			wake <= 1'b1;
			@(negedge clk);
			wake <= 1'b0;
			`CHK(bd, 1'b0)
			repeat (3) @(negedge clk);
			`CHK(bd, 1'b0)
			@(negedge clk);
			`CHK(bd, 1'b1)
			`CHK(bm, m)
			xfer(0, 1'b0, SZ_WORD, 32'h40, 0, rd((base + 32'h40) ^ K));
			`CHK(ls, NSLV'(1) << slot)
		end
	endtask
	task give_verdict;
		begin
			$display("errors %0d checks %0d", err_total, n_tests);
			if (err_total == 0 && n_tests > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// answer monitor
	always @(negedge clk)
		for (int i = 0; i < NMST; i++)
			if (m_ans[i].ready === 1'b1)
			begin
				`CHK(eq[i].size() != 0, 1'b1)
				ex = eq[i].size() > 0 ? eq[i].pop_front() : 34'h0;
				`CHK(m_ans[i].err, ex[32])
				if (ex[33])
					`CHK(m_ans[i].rdata, ex[31:0])
			end
	initial
	begin
		repeat (5000) @(posedge clk);
		err_total++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(48));
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		`CHK(ce, 30'h7)
		repeat (3) @(negedge clk);
		`CHK(bd, 1'b0)
		@(negedge clk);
		`CHK(bd, 1'b1)
		`CHK(bm, BOOT_SRAM)
		w = $urandom;
		xfer(0, 1'b1, SZ_WORD, 32'h2000_0100, w, 34'h0);
		xfer(1, 1'b1, SZ_BYTE, 32'h2000_0101, 32'h0000_AA00, 34'h0);
		xfer(0, 1'b1, SZ_HALF, 32'h2000_0102, 32'hBEEF_0000, 34'h0);
		a = {16'hBEEF, 8'hAA, w[7:0]};
		xfer(1, 1'b0, SZ_WORD, 32'h2000_0100, 0, rd(a));
		`CHK(lat <= 1, 1'b1)
		xfer(0, 1'b0, SZ_WORD, 32'h0000_0100, 0, rd(a));
		xfer(1, 1'b1, SZ_WORD, SRAM_LAST - 3, ~w, 34'h0);
		xfer(0, 1'b0, SZ_WORD, SRAM_LAST - 3, 0, rd(~w));
		fork
			xfer(0, 1'b0, SZ_WORD, 32'h2000_0100, 0, rd(a));
			xfer(1, 1'b0, SZ_WORD, FLASH_BASE + 8, 0, rd(FLASH_BASE + 8 ^ K));
		join
		fork
			xfer(0, 1'b0, SZ_WORD, SRAM_LAST - 3, 0, rd(~w));
			xfer(1, 1'b0, SZ_WORD, 32'h0000_0100, 0, rd(a));
		join
		for (k = 0; k < NSLV; k++)
		begin
			wc <= 2'(k % 3);
			a = 32'($urandom_range(255)) << 2;
			a = SLV_BASE[k] + (k == 2 ? a & 32'hC : a);
			xfer(k % 2, 1'b0, SZ_WORD, a, 0, rd(a ^ K));
			`CHK(ls, NSLV'(1) << k)
		end
		for (k = 0; k < 9; k++)
		begin
			pl = ls;
			xfer(k % 2, 1'b0, SZ_WORD, RSV[k], 0, 34'h3_0000_0000);
			`CHK(ls, pl)
		end
		xfer(0, 1'b1, SZ_BYTE, 32'h4000_0001, 32'h0000_AB00, 34'h0);
		`CHK(lw, 32'hABAB_ABAB)
		xfer(1, 1'b1, SZ_HALF, 32'h4001_0002, 32'hCDEF_0000, 34'h0);
		`CHK(lw, 32'hCDEF_CDEF)
		wc <= 2'h3;
		xfer(1, 1'b0, SZ_WORD, SLV_BASE[25], 0, 34'h1_0000_0000);
		wc <= 2'h0;
		cer <= NSLV'($urandom);
		repeat (2) @(negedge clk);
		`CHK(ce, cer | 30'h7)
		boot(1'b1, 1'b0, BOOT_SYSMEM, SYSMEM_BASE, 1);
		xfer(0, 1'b0, SZ_WORD, 32'h0000_0C00, 0, 34'h3_0000_0000);
		boot(1'b0, 1'b1, BOOT_FLASH, FLASH_BASE, 0);
		give_verdict();
	end
endmodule // system_address_decoder_tb
